// ### design/dsp_mac_block.sv
// Purpose: configurable multiply, accumulate and sum datapath
// Assumes: fabric extends narrow operands itself; x36 mode not built at this width
// Notes: shared clock sources arrive as enables synchronous to clk_sys_i
`default_nettype none
module dsp_mac_block
   import dsp_mac_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Shared stage sources
   input wire logic [NUM_SRC-1:0] shared_clock_source_i,
   input wire logic [NUM_SRC-1:0] shared_clock_enable_i,
   input wire logic [NUM_SRC-1:0] shared_reset_source_i,
   // Stage source selects: input, pipeline, output
   input wire logic [3*SEL_W-1:0] clk_sel_i,
   input wire logic [3*SEL_W-1:0] ce_sel_i,
   input wire logic [3*SEL_W-1:0] rst_sel_i,
   // Configuration
   input wire logic [1:0] elem_sel_i,
   input wire logic in_reg_en_i,
   input wire logic pipe_reg_en_i,
   input wire logic out_reg_en_i,
   input wire logic dynamic_en_i,
   input wire logic signed_cfg_i,
   input wire logic addsub_cfg_i,
   input wire logic shift_cfg_i,
   // Dynamic controls
   input wire logic signed_dyn_i,
   input wire logic [2:0] addsub_dyn_i,
   input wire logic shift_dyn_i,
   input wire logic acc_init_i,
   input wire logic [ACC_W-1:0] acc_load_i,
   // Operands
   input wire logic [NUM_OPS*OP_W-1:0] op_a_i,
   input wire logic [NUM_OPS*OP_W-1:0] op_b_i,
   input wire logic [OP_W-1:0] shift_a_i,
   input wire logic [OP_W-1:0] shift_b_i,
   // Results
   output logic [ACC_W-1:0] result_o,
   output logic overflow_o,
   output logic [OP_W-1:0] shift_a_o,
   output logic [OP_W-1:0] shift_b_o
);
   // Stage slots within the packed select ports
   localparam int IN_S = 0;
   localparam int PP_S = 1;
   localparam int OUT_S = 2;

   // Stage selectors, one per register stage
   stage_ctrl_if ctl_in ();
   stage_ctrl_if ctl_pp ();
   stage_ctrl_if ctl_out ();
   logic step_in, step_pp, step_out, clr_in, clr_pp, clr_out;

   // Input stage sources and selects
   assign ctl_in.clk_en = shared_clock_source_i;
   assign ctl_in.ce = shared_clock_enable_i;
   assign ctl_in.rst = shared_reset_source_i;
   assign ctl_in.clk_sel = clk_sel_i[IN_S*SEL_W +: SEL_W];
   assign ctl_in.ce_sel = ce_sel_i[IN_S*SEL_W +: SEL_W];
   assign ctl_in.rst_sel = rst_sel_i[IN_S*SEL_W +: SEL_W];

   // Pipeline stage sources and selects
   assign ctl_pp.clk_en = shared_clock_source_i;
   assign ctl_pp.ce = shared_clock_enable_i;
   assign ctl_pp.rst = shared_reset_source_i;
   assign ctl_pp.clk_sel = clk_sel_i[PP_S*SEL_W +: SEL_W];
   assign ctl_pp.ce_sel = ce_sel_i[PP_S*SEL_W +: SEL_W];
   assign ctl_pp.rst_sel = rst_sel_i[PP_S*SEL_W +: SEL_W];

   // Output stage sources and selects
   assign ctl_out.clk_en = shared_clock_source_i;
   assign ctl_out.ce = shared_clock_enable_i;
   assign ctl_out.rst = shared_reset_source_i;
   assign ctl_out.clk_sel = clk_sel_i[OUT_S*SEL_W +: SEL_W];
   assign ctl_out.ce_sel = ce_sel_i[OUT_S*SEL_W +: SEL_W];
   assign ctl_out.rst_sel = rst_sel_i[OUT_S*SEL_W +: SEL_W];

   // One selector per stage; all three see the same four sources
   stage_select u_sel_in (.ctl(ctl_in.sel));
   stage_select u_sel_pp (.ctl(ctl_pp.sel));
   stage_select u_sel_out (.ctl(ctl_out.sel));

   // Local names for the selected step and clear of each stage
   assign step_in = ctl_in.step;
   assign step_pp = ctl_pp.step;
   assign step_out = ctl_out.step;
   assign clr_in = ctl_in.clear;
   assign clr_pp = ctl_pp.clear;
   assign clr_out = ctl_out.clear;

   // Dynamic versus static control choice
   // Signedness: per-cycle control only when dynamic operation is on
   wire sgn_now = dynamic_en_i ? signed_dyn_i : signed_cfg_i;
   // Load mode: parallel or shift, switchable at run time
   wire shift_now = dynamic_en_i ? shift_dyn_i : shift_cfg_i;
   // Static add/sub applies one direction to every adder
   wire [2:0] addsub_now = dynamic_en_i ? addsub_dyn_i : {3{addsub_cfg_i}};

   // Input stage: operand registers with parallel or shift load
   logic [OP_W-1:0] a_q [NUM_OPS];
   logic [OP_W-1:0] b_q [NUM_OPS];
   logic [OP_W-1:0] a_ld [NUM_OPS];
   logic [OP_W-1:0] b_ld [NUM_OPS];
   logic [OP_W-1:0] a_use [NUM_OPS];
   logic [OP_W-1:0] b_use [NUM_OPS];
   logic sgn_in_q;

   genvar g;
   generate
      for (g = 0; g < NUM_OPS; g++) begin : g_op
         // Shift chain: operand 0 takes the neighbour input, others the previous register
         if (g == 0) begin : g_head
            assign a_ld[g] = shift_now ? shift_a_i : op_a_i[g*OP_W +: OP_W];
            assign b_ld[g] = shift_now ? shift_b_i : op_b_i[g*OP_W +: OP_W];
         end else begin : g_tail
            assign a_ld[g] = shift_now ? a_q[g-1] : op_a_i[g*OP_W +: OP_W];
            assign b_ld[g] = shift_now ? b_q[g-1] : op_b_i[g*OP_W +: OP_W];
         end
         // Bypass when input register not in use
         assign a_use[g] = in_reg_en_i ? a_q[g] : op_a_i[g*OP_W +: OP_W];
         assign b_use[g] = in_reg_en_i ? b_q[g] : op_b_i[g*OP_W +: OP_W];
         always_ff @(posedge clk_sys_i) begin
            if (!nrst_i || clr_in) begin
               a_q[g] <= '0;
               b_q[g] <= '0;
            end else if (step_in) begin
               a_q[g] <= a_ld[g];
               b_q[g] <= b_ld[g];
            end
         end
      end
   endgenerate

   // Signedness travels with the operands through the input stage
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || clr_in) begin
         sgn_in_q <= 1'b0;
      end else if (step_in) begin
         sgn_in_q <= sgn_now;
      end
   end
   // Bypassed input stage passes the live signedness
   wire sgn_use = in_reg_en_i ? sgn_in_q : sgn_now;

   // Multipliers; one shared signedness for all operands of the element
   logic [PROD_W-1:0] prod [NUM_OPS];
   generate
      for (g = 0; g < NUM_OPS; g++) begin : g_mul
         // Extra top bit lets one signed multiplier serve both signednesses
         wire signed [OP_W:0] a_x = {sgn_use & a_use[g][OP_W-1], a_use[g]};
         wire signed [OP_W:0] b_x = {sgn_use & b_use[g][OP_W-1], b_use[g]};
         wire signed [2*OP_W+1:0] p_x = a_x * b_x;
         assign prod[g] = p_x[PROD_W-1:0];
      end
   endgenerate

   // Pipeline stage
   logic [PROD_W-1:0] prod_q [NUM_OPS];
   logic [PROD_W-1:0] prod_use [NUM_OPS];
   logic sgn_pp_q;
   logic [2:0] addsub_pp_q;
   generate
      for (g = 0; g < NUM_OPS; g++) begin : g_pp
         always_ff @(posedge clk_sys_i) begin
            if (!nrst_i || clr_pp) begin
               prod_q[g] <= '0;
            end else if (step_pp) begin
               prod_q[g] <= prod[g];
            end
         end
         assign prod_use[g] = pipe_reg_en_i ? prod_q[g] : prod[g];
      end
   endgenerate
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || clr_pp) begin
         sgn_pp_q <= 1'b0;
         addsub_pp_q <= 3'h0;
      end else if (step_pp) begin
         sgn_pp_q <= sgn_use;
         addsub_pp_q <= addsub_now;
      end
   end
   // Controls follow the products through the pipeline stage
   wire sgn_pp = pipe_reg_en_i ? sgn_pp_q : sgn_use;
   wire [2:0] addsub_pp = pipe_reg_en_i ? addsub_pp_q : addsub_now;

   // Extend products to accumulator width by signedness
   // Sign bit copies only for signed elements; unsigned zero-fills
   logic [ACC_W-1:0] px [NUM_OPS];
   generate
      for (g = 0; g < NUM_OPS; g++) begin : g_ext
         assign px[g] = {{(ACC_W-PROD_W){sgn_pp & prod_use[g][PROD_W-1]}}, prod_use[g]};
      end
   endgenerate

   // Pair add/sub; bit 0 is first pair, bit 1 second pair (1 = subtract)
   // First pair serves both the two-product and four-product elements
   wire [ACC_W-1:0] pair01 = addsub_pp[0] ? px[0] - px[1] : px[0] + px[1];
   // Second pair only matters to the four-product element
   wire [ACC_W-1:0] pair23 = addsub_pp[1] ? px[2] - px[3] : px[2] + px[3];
   // Summation of both pair results; wraps at accumulator width
   wire [ACC_W-1:0] sum4 = pair01 + pair23;

   // Accumulator path; bit 2 selects subtraction
   logic [ACC_W-1:0] acc_q;
   logic ovf_q;
   wire acc_sub = addsub_pp[2];
   // Both directions formed one bit wider; the top bit is carry or borrow
   wire [ACC_W:0] acc_plus = {1'b0, acc_q} + {1'b0, px[0]};
   wire [ACC_W:0] acc_minus = {1'b0, acc_q} - {1'b0, px[0]};
   wire [ACC_W:0] acc_wide = acc_sub ? acc_minus : acc_plus;

   wire [ACC_W-1:0] acc_sum = acc_wide[ACC_W-1:0];
   wire [ACC_W-1:0] addend = acc_sub ? ~px[0] : px[0];
   wire acc_msb = acc_q[ACC_W-1];
   wire add_msb = addend[ACC_W-1];
   wire sum_msb = acc_sum[ACC_W-1];
   // Unsigned wrap: carry out on add, borrow on subtract; signed: sign violation
   wire ovf_u = acc_wide[ACC_W];
   wire ovf_s = (acc_msb == add_msb) && (sum_msb != acc_msb);
   // Signedness picks which overflow test applies
   wire ovf_now = sgn_pp ? ovf_s : ovf_u;

   // Combined result before the output stage
   logic [ACC_W-1:0] comb_res;
   always_comb begin
      case (elem_e'(elem_sel_i))
         ELEM_PLAIN_MULTIPLY_ELEMENT: comb_res = px[0];
         ELEM_ADDSUB: comb_res = pair01;
         ELEM_SUM: comb_res = sum4;
         default: comb_res = px[0];
      endcase
   end
   wire is_mac = (elem_e'(elem_sel_i) == ELEM_MAC);

   // Output stage: accumulator always registered, other elements optional
   logic [ACC_W-1:0] res_q;
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || clr_out) begin
         acc_q <= '0;
         ovf_q <= 1'b0;
      end else if (step_out && is_mac) begin
         if (acc_init_i) begin
            acc_q <= acc_load_i;
            ovf_q <= 1'b0;
         end else begin
            acc_q <= acc_sum;
            ovf_q <= ovf_now;
         end
      end else begin
         ovf_q <= 1'b0;
      end
   end

   // Result register for the non-accumulating elements
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || clr_out) begin
         res_q <= '0;
      end else if (step_out) begin
         res_q <= comb_res;
      end
   end

   // Final registers: result output always from a flip-flop
   // Unregistered output mode costs one extra flop of latency from clk_sys_i only
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         result_o <= '0;
      end else begin
         if (is_mac) begin
            result_o <= acc_q;
         end else if (out_reg_en_i) begin
            result_o <= res_q;
         end else begin
            result_o <= comb_res;
         end
      end
   end

   // Flag copy trails ovf_q by one flop, in step with the result
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         overflow_o <= 1'b0;
      end else begin
         overflow_o <= ovf_q;
      end
   end

   // Chain end to the neighbour block; registered so a cascade adds no path
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         shift_a_o <= '0;
         shift_b_o <= '0;
      end else begin
         shift_a_o <= a_q[NUM_OPS-1];
         shift_b_o <= b_q[NUM_OPS-1];
      end
   end
endmodule
`default_nettype wire

// ### design/dsp_mac_pkg.sv
// Purpose: constants and types for the multiply-accumulate datapath block
// Assumes: one system clock; stage clocks are modelled as shared enable sources
// Notes: widths fixed at the widest operand width of the block
`default_nettype none
package dsp_mac_pkg;
   localparam int OP_W = 18;
   localparam int PROD_W = 2 * OP_W;
   localparam int ACC_W = 52;
   localparam int NUM_OPS = 4;
   localparam int NUM_SRC = 4;
   localparam int SEL_W = 2;
   localparam logic [1:0] WIDTH_X9 = 2'h0;
   localparam logic [1:0] WIDTH_X18 = 2'h1;
   localparam logic [1:0] WIDTH_X36 = 2'h2;
   typedef enum logic [1:0] {
      ELEM_PLAIN_MULTIPLY_ELEMENT = 2'b00,
      ELEM_MAC = 2'b01,
      ELEM_ADDSUB = 2'b10,
      ELEM_SUM = 2'b11
   } elem_e;
endpackage
`default_nettype wire

// ### design/stage_ctrl_if.sv
// Purpose: per-stage clock, enable and reset selection carrier
// Assumes: selects are static configuration
// Notes: shared between the top and the stage selector
`default_nettype none
interface stage_ctrl_if;
   import dsp_mac_pkg::*;
   logic [NUM_SRC-1:0] clk_en;
   logic [NUM_SRC-1:0] ce;
   logic [NUM_SRC-1:0] rst;
   logic [SEL_W-1:0] clk_sel;
   logic [SEL_W-1:0] ce_sel;
   logic [SEL_W-1:0] rst_sel;
   logic step;
   logic clear;
   modport sel (input clk_en, ce, rst, clk_sel, ce_sel, rst_sel, output step, clear);
   modport src (output clk_en, ce, rst, clk_sel, ce_sel, rst_sel, input step, clear);
endinterface
`default_nettype wire

// ### design/stage_select.sv
// Purpose: picks clock, enable and reset source for one register stage
// Assumes: shared clock sources appear as clock-edge qualifiers of clk_sys_i
// Notes: purely combinational; the stage registers live in the top
`default_nettype none
module stage_select
   import dsp_mac_pkg::*;
(
   stage_ctrl_if.sel ctl
);
   // One edge of the chosen clock, gated by the chosen enable
   assign ctl.step = ctl.clk_en[ctl.clk_sel] & ctl.ce[ctl.ce_sel];
   // Reset wins over the step in the stage
   assign ctl.clear = ctl.rst[ctl.rst_sel];
endmodule
`default_nettype wire

// ### dv/dsp_mac_properties.sv
// Purpose: port-level checks of the accumulate datapath
// Assumes: stage selects [1:0] input, [5:4] output
// Notes: result and flag trail the accumulator by one flop
`default_nettype none
module dsp_mac_checker
   import dsp_mac_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Stage sources and selects
   input wire logic [NUM_SRC-1:0] shared_clock_source_i,
   input wire logic [NUM_SRC-1:0] shared_clock_enable_i,
   input wire logic [NUM_SRC-1:0] shared_reset_source_i,
   input wire logic [3*SEL_W-1:0] clk_sel_i,
   input wire logic [3*SEL_W-1:0] ce_sel_i,
   input wire logic [3*SEL_W-1:0] rst_sel_i,
   // Configuration and controls
   input wire logic [1:0] elem_sel_i,
   input wire logic in_reg_en_i,
   input wire logic out_reg_en_i,
   input wire logic acc_init_i,
   input wire logic [ACC_W-1:0] acc_load_i,
   // Results
   input wire logic [ACC_W-1:0] result_o,
   input wire logic overflow_o,
   input wire logic [OP_W-1:0] shift_a_o
);
   // Output stage step and stage resets as the selects pick them
   wire logic out_go = shared_clock_source_i[clk_sel_i[5:4]] && shared_clock_enable_i[ce_sel_i[5:4]];
   wire logic out_rst = shared_reset_source_i[rst_sel_i[5:4]];
   wire logic in_rst = shared_reset_source_i[rst_sel_i[1:0]];
   wire logic mac = elem_sel_i == ELEM_MAC;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   reset_clears_outputs_a: assert property ($rose(nrst_i) |-> result_o == '0 && !overflow_o)
      else $error("outputs not clear after reset");
   init_loads_total_a: assert property (mac && out_go && !out_rst && acc_init_i |-> ##2 result_o == $past(acc_load_i, 2))
      else $error("load value not taken");
   init_clears_flag_a: assert property (mac && out_go && !out_rst && acc_init_i |-> ##2 !overflow_o)
      else $error("flag set after load");
   out_reset_zero_a: assert property ((mac || out_reg_en_i) && out_rst |-> ##2 result_o == '0)
      else $error("output stage not cleared");
   acc_hold_a: assert property ((mac && !out_go && !out_rst)[*2] |-> ##1 $stable(result_o))
      else $error("total moved without a step");
   overflow_pulse_a: assert property (overflow_o |=> !overflow_o)
      else $error("flag longer than one cycle");
   overflow_mode_a: assert property (overflow_o |-> mac)
      else $error("flag outside accumulate mode");
   overflow_cause_a: assert property (overflow_o |-> $past(mac && out_go && !acc_init_i, 2))
      else $error("flag without accumulate step");
   shift_reset_a: assert property ((in_reg_en_i && in_rst)[*2] |-> ##1 shift_a_o == '0)
      else $error("input stage not cleared");
endmodule
bind dsp_mac_block dsp_mac_checker dsp_mac_checker_inst (.*);
`default_nettype wire

// ### dv/fabric_operand_src.sv
// Purpose: fabric-side operand source widening narrow values
// Assumes: narrow value and signedness come from fabric logic
// Notes: feeds the neighbour shift inputs of the block
`default_nettype none
module fabric_operand_src
   import dsp_mac_pkg::*;
#(
   parameter int NW = 4
) (
   // Narrow operand and signedness
   input wire logic [NW-1:0] val_i,
   input wire logic sgn_i,
   // Full-width operand
   output logic [OP_W-1:0] op_o
);
   // Zero fill keeps the magnitude, sign copy keeps the value
   assign op_o = sgn_i ? {{(OP_W - NW){val_i[NW-1]}}, val_i} : {{(OP_W - NW){1'b0}}, val_i};
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: self-checking bench for the accumulate datapath
// Assumes: output stage on source 2, enable 1, reset 3
// Notes: waits are the fixed latencies of the hand-over
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dsp_mac_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] src = 4'hF, ce = 4'hF, rs = 4'h0, nib = 4'h0;
   logic [1:0] elem = 2'h0;
   logic sgn = 1'b0, shf = 1'b0, init = 1'b0, en = 1'b1, dyn = 1'b1, ovf;
   logic [2:0] sub = 3'h0;
   logic [ACC_W-1:0] load = '0, res;
   logic [71:0] opa = {18'h00004, 18'h00003, 18'h00002, 18'h3FFFF};
   logic [71:0] opb = {18'h00006, 18'h00005, 18'h00007, 18'h00002};
   logic [OP_W-1:0] sha, sao, sbo;
   int failures = 0, total_checks = 0, n_ovf = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   // Flag pulses counted away from the sampling edge
   always @(negedge clk_sys_i) n_ovf += (ovf === 1'b1);
   fabric_operand_src #(.NW(4)) fabric_operand_src_inst (.val_i(nib), .sgn_i(sgn), .op_o(sha));
   dsp_mac_block dsp_mac_block_inst (.clk_sys_i, .nrst_i, .shared_clock_source_i(src),
      .shared_clock_enable_i(ce), .shared_reset_source_i(rs), .clk_sel_i(6'h20), .ce_sel_i(6'h10),
      .rst_sel_i(6'h30), .elem_sel_i(elem), .in_reg_en_i(en), .pipe_reg_en_i(en), .out_reg_en_i(en),
      .dynamic_en_i(dyn), .signed_cfg_i(sgn), .addsub_cfg_i(sub[0]), .shift_cfg_i(shf),
      .signed_dyn_i(sgn), .addsub_dyn_i(sub), .shift_dyn_i(shf), .acc_init_i(init), .acc_load_i(load),
      .op_a_i(opa), .op_b_i(opb), .shift_a_i(sha), .shift_b_i(sha), .result_o(res), .overflow_o(ovf),
      .shift_a_o(sao), .shift_b_o(sbo));
   function automatic logic [ACC_W-1:0] xprod(input logic [OP_W-1:0] a, b, input logic s);
      logic signed [ACC_W-1:0] r;
      if (s) r = $signed(a) * $signed(b);
      else r = a * b;
      return r;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Product, pair and sum elements; lat is edges to a settled result
   task automatic prod_case(input logic [1:0] e, input logic s, input logic [2:0] m, input int lat);
      logic [ACC_W-1:0] p[4];
      logic [ACC_W-1:0] x;
      for (int k = 0; k < 4; k++) p[k] = xprod(opa[18*k+:18], opb[18*k+:18], s);
      x = m[0] ? p[0] - p[1] : p[0] + p[1];
      if (e == ELEM_PLAIN_MULTIPLY_ELEMENT) x = p[0];
      if (e == ELEM_SUM) x += m[1] ? p[2] - p[3] : p[2] + p[3];
      @(posedge clk_sys_i);
      elem <= e;
      sgn <= s;
      sub <= m;
      tick(lat);
      #1 `CHK(res, x)
   endtask
   // Load, run n accumulate steps, stop by the output enable
   task automatic mac_case(input logic s, u, input logic [ACC_W-1:0] l, input logic [OP_W-1:0] a, input int n, nv);
      logic [ACC_W-1:0] x;
      x = l;
      repeat (n) x = u ? x - xprod(a, 18'h00007, s) : x + xprod(a, 18'h00007, s);
      @(posedge clk_sys_i);
      {elem, sgn, sub, init, ce[1]} <= {ELEM_MAC, s, u, 2'h0, 2'h3};
      {opa[17:0], opb[17:0], load} <= {a, 18'h00007, l};
      n_ovf = 0;
      tick(3);
      init <= 1'b0;
      tick(n);
      ce[1] <= 1'b0;
      tick(3);
      #1 `CHK(res, x)
      `CHK(n_ovf, nv)
   endtask
   // Shift chain fed from the fabric source into operand 0
   task automatic shift_case(input logic [3:0] v, input logic s, input logic [ACC_W-1:0] x, input logic [OP_W-1:0] w);
      @(posedge clk_sys_i);
      {elem, sgn, shf, nib} <= {ELEM_PLAIN_MULTIPLY_ELEMENT, s, 1'b1, v};
      tick(6);
      #1 `CHK(sao, w)
      `CHK(sbo, w)
      `CHK(res, x)
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      tick(20);
      nrst_i <= 1'b1;
      tick(2);
      #1 `CHK(res, 52'h0)
      shift_case(4'h5, 1'b0, 52'h19, 18'h00005);
      shift_case(4'hD, 1'b1, 52'h9, 18'h3FFFD);
      @(posedge clk_sys_i);
      shf <= 1'b0;
      $display("shift load done");
      prod_case(ELEM_PLAIN_MULTIPLY_ELEMENT, 1'b0, 3'h0, 4);
      prod_case(ELEM_PLAIN_MULTIPLY_ELEMENT, 1'b1, 3'h0, 4);
      prod_case(ELEM_ADDSUB, 1'b1, 3'h0, 4);
      prod_case(ELEM_ADDSUB, 1'b1, 3'h1, 4);
      prod_case(ELEM_SUM, 1'b0, 3'h2, 4);
      prod_case(ELEM_SUM, 1'b1, 3'h1, 4);
      // Static controls: signedness and add/sub from the configuration inputs
      dyn <= 1'b0;
      prod_case(ELEM_ADDSUB, 1'b1, 3'h1, 4);
      dyn <= 1'b1;
      en <= 1'b0;
      prod_case(ELEM_PLAIN_MULTIPLY_ELEMENT, 1'b0, 3'h0, 1);
      en <= 1'b1;
      $display("product elements done");
      mac_case(1'b0, 1'b0, 52'h64, 18'h3, 3, 0);
      mac_case(1'b0, 1'b1, 52'h64, 18'h3, 2, 0);
      mac_case(1'b0, 1'b0, 52'hFFFFFFFFFFFF0, 18'h3, 1, 1);
      mac_case(1'b1, 1'b0, 52'h7FFFFFFFFFFF0, 18'h3, 1, 1);
      mac_case(1'b1, 1'b0, 52'h8000000000005, 18'h3FFFD, 1, 1);
      mac_case(1'b0, 1'b1, 52'h5, 18'h3, 1, 1);
      $display("accumulate done");
      @(posedge clk_sys_i);
      {ce[1], src[2]} <= 2'h2;
      tick(4);
      #1 `CHK(res, 52'hFFFFFFFFFFFF0)
      @(posedge clk_sys_i);
      {rs, src[2]} <= 5'h13;
      tick(2);
      rs <= 4'h0;
      ce[1] <= 1'b0;
      #1 `CHK(res, 52'h0)
      `CHK(sao, 18'h00000)
      $display("stage sources done");
      final_report();
   end
endmodule
`default_nettype wire
